// ==== hw/dsc_setup_regs.sv ====
// device setup control register bank: one device-wide configuration word,
// written and read back through framed serial command words, with
// clamp and comparator enables shared with the per-channel registers.
// assumes cmd_valid_i marks a complete 29-bit word, synchronous to mclk_i,
// and that the channel decoder pulses chan_wr_i for channel register writes.
//
// Contract
// - setup register is targeted only when channel and target bits are zero
// - one register serves the whole device, not one per channel
// - top command bit zero writes, one starts a readback
// - four clamp enable bits switch each channel clamp on or off
// - clamp enable shared with channel register, readback shows latest write
// - comparator output enables drive outputs, high impedance after power-on
// - comparator output drives only while global comparator power is set
// - comparator power resets to zero, one powers all, zero shuts down
// - ground sense bit turns guard inputs into per-channel ground sense
// - two alarm selects route guard and clamp alarms onto shared pin
// - sense short bit closes both ten kilohm short switches
// - guard amplifier enable resets to zero, one enables it
// - upper gain bit selects unipolar measure range, else follows span
`timescale 1ns/1ps
`default_nettype none

module dsc_setup_regs #(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // framed command word
  input  wire logic                      cmd_valid_i,
  input  wire logic [dsc_pkg::CMD_W-1:0] cmd_word_i,
  // per-channel register writes of the shared enables
  input  wire logic [CHANNELS-1:0]       chan_wr_i,
  input  wire logic                      chan_clamp_en_i,
  input  wire logic                      chan_cmp_en_i,
  // live analog inputs
  input  wire logic [CHANNELS-1:0]       cmp_result_i,
  input  wire logic [CHANNELS-1:0]       guard_alarm_i,
  input  wire logic [CHANNELS-1:0]       clamp_alarm_i,
  // readback
  output logic                           rd_valid_o,
  output logic [dsc_pkg::DATA_W-1:0]     rd_data_o,
  // device-wide controls
  output logic [CHANNELS-1:0]            clamp_en_o,
  output logic [CHANNELS-1:0]            cmp_out_en_o,
  output logic                           cmp_power_on_o,
  output logic [CHANNELS-1:0]            cmp_out_o,
  output logic [CHANNELS-1:0]            cmp_out_oe_o,
  output logic                           ground_sense_per_channel_o,
  output logic                           guard_alarm_select_o,
  output logic                           clamp_alarm_select_o,
  output logic                           shared_alarm_pin_o,
  output logic                           shared_alarm_pin_oe_o,
  output logic                           sense_short_switch_o,
  output logic                           ground_short_switch_o,
  output logic                           guard_amp_en_o,
  output logic                           meas_range_unipolar_o,
  output logic                           meas_current_gain_sel_o,
  output logic                           tmp_en_o,
  output logic [1:0]                     tmp_sel_o,
  output logic                           latched_o
);

  // true when a word addresses the setup register, whatever its direction
  function automatic logic targets_setup(
    input logic [dsc_pkg::CMD_W-1:0] w
  );
    logic hit;
    hit = 1'b0;
    hit = (w[dsc_pkg::CHAN_SEL_MSB:dsc_pkg::CHAN_SEL_LSB] == 4'h0) &&
          (w[dsc_pkg::TARGET_MSB:dsc_pkg::TARGET_LSB] == 2'h0);
    return hit;
  endfunction

  // unpack a data word into the register image; low two bits dropped
  function automatic dsc_pkg::dsc_setup_t unpack_setup(
    input logic [dsc_pkg::DATA_W-1:0] d
  );
    dsc_pkg::dsc_setup_t s;
    s = '0;
    s.clamp_en                 = d[dsc_pkg::CLAMP_LSB +: 4];
    s.cmp_out_en               = d[dsc_pkg::CMP_OE_LSB +: 4];
    s.cmp_power_on             = d[dsc_pkg::CMP_PWR_POS];
    s.ground_sense_per_channel = d[dsc_pkg::GND_SNS_POS];
    s.guard_alarm_select       = d[dsc_pkg::GALM_POS];
    s.clamp_alarm_select       = d[dsc_pkg::CALM_POS];
    s.internal_sense_short     = d[dsc_pkg::SSHORT_POS];
    s.guard_amp_en             = d[dsc_pkg::GUARD_POS];
    s.meas_range_unipolar      = d[dsc_pkg::GAIN_HI_POS];
    s.meas_current_gain_sel    = d[dsc_pkg::GAIN_LO_POS];
    s.tmp_en                   = d[dsc_pkg::TMP_EN_POS];
    s.tmp_sel                  = d[dsc_pkg::TMP_SEL_LSB +: 2];
    s.latched                  = d[dsc_pkg::LATCHED_POS];
    return s;
  endfunction

  // pack the register image back into a readback word
  function automatic logic [dsc_pkg::DATA_W-1:0] pack_setup(
    input dsc_pkg::dsc_setup_t s
  );
    logic [dsc_pkg::DATA_W-1:0] d;
    d = '0;
    d[dsc_pkg::CLAMP_LSB +: 4]     = s.clamp_en;
    d[dsc_pkg::CMP_OE_LSB +: 4]    = s.cmp_out_en;
    d[dsc_pkg::CMP_PWR_POS]        = s.cmp_power_on;
    d[dsc_pkg::GND_SNS_POS]        = s.ground_sense_per_channel;
    d[dsc_pkg::GALM_POS]           = s.guard_alarm_select;
    d[dsc_pkg::CALM_POS]           = s.clamp_alarm_select;
    d[dsc_pkg::SSHORT_POS]         = s.internal_sense_short;
    d[dsc_pkg::GUARD_POS]          = s.guard_amp_en;
    d[dsc_pkg::GAIN_HI_POS]        = s.meas_range_unipolar;
    d[dsc_pkg::GAIN_LO_POS]        = s.meas_current_gain_sel;
    d[dsc_pkg::TMP_EN_POS]         = s.tmp_en;
    d[dsc_pkg::TMP_SEL_LSB +: 2]   = s.tmp_sel;
    d[dsc_pkg::LATCHED_POS]        = s.latched;
    return d;
  endfunction

  dsc_pkg::dsc_state_t        state_reg;
  dsc_pkg::dsc_state_t        state_next;
  logic                       setup_hit;
  logic                       wr_hit;
  logic                       rd_hit;
  logic [CHANNELS-1:0]        guard_flag;
  logic [CHANNELS-1:0]        clamp_flag;

  // command decode, shared by write and readback paths
  assign setup_hit = cmd_valid_i && targets_setup(cmd_word_i);
  assign wr_hit    = setup_hit && !cmd_word_i[dsc_pkg::DIR_POS];
  assign rd_hit    = setup_hit &&  cmd_word_i[dsc_pkg::DIR_POS];

  // next state: setup writes, channel writes of shared bits, readback
  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;
    // channel register writes land first so a setup write in the same
    // cycle, being the later of the two in the command order, wins
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      if (chan_wr_i[c]) begin
        state_next.setup.clamp_en[c]   = chan_clamp_en_i;
        state_next.setup.cmp_out_en[c] = chan_cmp_en_i;
      end
    end
    if (wr_hit) begin
      state_next.setup = unpack_setup(cmd_word_i[dsc_pkg::DATA_W-1:0]);
    end
    // readback shows the image as it stands before this word's effect
    if (rd_hit) begin
      state_next.rd_valid = 1'b1;
      state_next.rd_data  = pack_setup(state_reg.setup);
    end
  end

  // single state register, synchronous power-on reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg.setup    <= unpack_setup(dsc_pkg::SETUP_RESET);
      state_reg.rd_valid <= 1'b0;
      state_reg.rd_data  <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // readback port
  assign rd_valid_o = state_reg.rd_valid;
  assign rd_data_o  = state_reg.rd_data;

  assign clamp_en_o     = state_reg.setup.clamp_en;
  // channel readback uses the same bits
  assign cmp_out_en_o   = state_reg.setup.cmp_out_en;
  assign cmp_power_on_o = state_reg.setup.cmp_power_on;

  // comparator outputs: a powered-down comparator has nothing to drive,
  // so the enable alone is not enough; both must be set
  // high impedance until enabled
  assign cmp_out_oe_o = state_reg.setup.cmp_out_en &
                        {CHANNELS{state_reg.setup.cmp_power_on}};
  assign cmp_out_o    = cmp_result_i & cmp_out_oe_o;

  assign ground_sense_per_channel_o = state_reg.setup.ground_sense_per_channel;

  assign guard_alarm_select_o = state_reg.setup.guard_alarm_select;
  assign clamp_alarm_select_o = state_reg.setup.clamp_alarm_select;

  // open-drain alarm: only ever pulls low, never drives high;
  // with both selects clear the pin is released whatever the sources do
  // source gating
  assign guard_flag = guard_alarm_i & {CHANNELS{state_reg.setup.guard_alarm_select}};
  assign clamp_flag = clamp_alarm_i & {CHANNELS{state_reg.setup.clamp_alarm_select}};
  assign shared_alarm_pin_o    = 1'b0;
  assign shared_alarm_pin_oe_o = (|guard_flag) | (|clamp_flag);

  // both short switches follow one bit, so they can never disagree
  // sense and ground shorts
  assign sense_short_switch_o  = state_reg.setup.internal_sense_short;
  assign ground_short_switch_o = state_reg.setup.internal_sense_short;

  assign guard_amp_en_o = state_reg.setup.guard_amp_en;

  assign meas_range_unipolar_o   = state_reg.setup.meas_range_unipolar;
  assign meas_current_gain_sel_o = state_reg.setup.meas_current_gain_sel;

  // temperature shutdown settings, passed to the sensor block
  assign tmp_en_o  = state_reg.setup.tmp_en;
  assign tmp_sel_o = state_reg.setup.tmp_sel;
  assign latched_o = state_reg.setup.latched;

endmodule

`default_nettype wire

// ==== hw/dsc_pkg.sv ====
// device setup control package: command word layout, field positions,
// reset values and the packed state types of the setup register bank.
// assumes a 29-bit command word already shifted in and framed upstream.
package dsc_pkg;

  // command word layout
  localparam int unsigned CMD_W        = 29;
  localparam int unsigned DIR_POS      = 28;   // 1 = readback, 0 = write
  localparam int unsigned CHAN_SEL_MSB = 27;
  localparam int unsigned CHAN_SEL_LSB = 24;
  localparam int unsigned TARGET_MSB   = 23;
  localparam int unsigned TARGET_LSB   = 22;
  localparam int unsigned DATA_W       = 22;   // data bits 21..0

  // data field positions inside the setup word
  localparam int unsigned CLAMP_LSB    = 18;   // 21..18
  localparam int unsigned CMP_OE_LSB   = 14;   // 17..14
  localparam int unsigned CMP_PWR_POS  = 13;
  localparam int unsigned GND_SNS_POS  = 12;
  localparam int unsigned GALM_POS     = 11;
  localparam int unsigned CALM_POS     = 10;
  localparam int unsigned SSHORT_POS   = 9;
  localparam int unsigned GUARD_POS    = 8;
  localparam int unsigned GAIN_HI_POS  = 7;
  localparam int unsigned GAIN_LO_POS  = 6;
  localparam int unsigned TMP_EN_POS   = 5;
  localparam int unsigned TMP_SEL_LSB  = 3;    // 4..3
  localparam int unsigned LATCHED_POS  = 2;

  // power-on values: every function off, guard-input use, alarm pin off
  localparam logic [21:0] SETUP_RESET  = 22'h000000;
  localparam logic [3:0]  CHAN_ZERO    = 4'h0;

  // register image of the setup word, low two bits always zero
  typedef struct packed {
    logic [3:0] clamp_en;
    logic [3:0] cmp_out_en;
    logic       cmp_power_on;
    logic       ground_sense_per_channel;
    logic       guard_alarm_select;
    logic       clamp_alarm_select;
    logic       internal_sense_short;
    logic       guard_amp_en;
    logic       meas_range_unipolar;
    logic       meas_current_gain_sel;
    logic       tmp_en;
    logic [1:0] tmp_sel;
    logic       latched;
  } dsc_setup_t;

  // whole state of the block
  typedef struct packed {
    dsc_setup_t        setup;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
  } dsc_state_t;

endpackage

// ==== testbench/dsc_checker.sv ====
// checker for the setup register bank, sees only top module ports
// assumes a bind into dsc_setup_regs with ports of the same names
`timescale 1ns/1ps
`default_nettype none
module dsc_checker (
  input wire logic        mclk_i, rst_i, cmd_valid_i, chan_clamp_en_i, chan_cmp_en_i,
  input wire logic [28:0] cmd_word_i,
  input wire logic [3:0]  chan_wr_i, cmp_result_i, guard_alarm_i, clamp_alarm_i,
  input wire logic [3:0]  clamp_en_o, cmp_out_en_o, cmp_out_o, cmp_out_oe_o,
  input wire logic        cmp_power_on_o, ground_sense_per_channel_o, guard_alarm_select_o,
  input wire logic        clamp_alarm_select_o, shared_alarm_pin_o, shared_alarm_pin_oe_o,
  input wire logic        sense_short_switch_o, ground_short_switch_o, guard_amp_en_o,
  input wire logic        meas_range_unipolar_o, meas_current_gain_sel_o, tmp_en_o,
  input wire logic        latched_o, rd_valid_o,
  input wire logic [1:0]  tmp_sel_o,
  input wire logic [21:0] rd_data_o
);
  // field image in setup layout, unused low bits left out
  wire logic [19:0] img = {clamp_en_o, cmp_out_en_o, cmp_power_on_o,
    ground_sense_per_channel_o, guard_alarm_select_o, clamp_alarm_select_o,
    sense_short_switch_o, guard_amp_en_o, meas_range_unipolar_o,
    meas_current_gain_sel_o, tmp_en_o, tmp_sel_o, latched_o};
  wire logic [19:0] wdat = cmd_word_i[21:2];
  wire logic wr_req = cmd_valid_i && cmd_word_i[28:22] == 7'h00;
  wire logic rd_req = cmd_valid_i && cmd_word_i[28:22] == 7'h40;
  wire logic fgn = cmd_valid_i && cmd_word_i[27:22] != 6'h00 && chan_wr_i == 4'h0;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // a read answers next cycle with the image held before it
  sequence s_rd_ans;
    rd_req ##1 rd_valid_o;
  endsequence
  a_write_fields: assert property (wr_req |=> img == $past(wdat))
    else $error("setup write not applied");
  a_foreign_kept: assert property (fgn |=> $stable(img))
    else $error("foreign word changed setup");
  a_read_answer: assert property (rd_req |=> rd_valid_o)
    else $error("read not answered");
  a_read_image: assert property (s_rd_ans |-> rd_data_o == {$past(img), 2'h0})
    else $error("readback image wrong");
  a_read_cause: assert property (rd_valid_o |-> $past(rd_req))
    else $error("readback without read word");
  a_oe_gate: assert property (cmp_out_oe_o == (cmp_out_en_o & {4{cmp_power_on_o}}))
    else $error("comparator drive not gated");
  a_alarm_route: assert property (shared_alarm_pin_oe_o == ((|(guard_alarm_i)
    && guard_alarm_select_o) || (|(clamp_alarm_i) && clamp_alarm_select_o)))
    else $error("alarm pin routing wrong");
  a_cmp_drive: assert property (cmp_out_o == (cmp_result_i & cmp_out_oe_o))
    else $error("comparator output driven while disabled");
  a_alarm_low: assert property (shared_alarm_pin_o == 1'b0)
    else $error("open drain alarm drove high");
  a_short_pair: assert property (sense_short_switch_o == ground_short_switch_o)
    else $error("short switches differ");
  a_chan_share: assert property (chan_wr_i[0] && !wr_req |=> clamp_en_o[0] ==
    $past(chan_clamp_en_i) && cmp_out_en_o[0] == $past(chan_cmp_en_i))
    else $error("channel write not shared");
endmodule
`default_nettype wire

// ==== testbench/dsc_host_model.sv ====
// host model: issues framed command words to the setup register bank
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
  input  wire logic   mclk_i,
  output logic        cmd_valid_o,
  output logic [28:0] cmd_word_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o  = 29'h0;
  end
  // word goes stale after its cycle so the device cannot lean on hold
  task automatic send(input logic [28:0] w);
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_word_o  = w;
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_word_o  = ~w;
  endtask
  task automatic wr(input logic [21:0] d);
    send({7'h00, d[21:2], 2'h0});
  endtask
  task automatic rd();
    send(29'h10000000);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// top bench: drives host words, channel writes and live inputs
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk_i, rst_i, cmd_valid_i, chan_clamp_en_i, chan_cmp_en_i, rd_valid_o;
  logic        cmp_power_on_o, ground_sense_per_channel_o, guard_alarm_select_o;
  logic        clamp_alarm_select_o, shared_alarm_pin_o, shared_alarm_pin_oe_o;
  logic        sense_short_switch_o, ground_short_switch_o, guard_amp_en_o, latched_o;
  logic        meas_range_unipolar_o, meas_current_gain_sel_o, tmp_en_o;
  logic [1:0]  tmp_sel_o;
  logic [3:0]  chan_wr_i, cmp_result_i, guard_alarm_i, clamp_alarm_i;
  logic [3:0]  clamp_en_o, cmp_out_en_o, cmp_out_o, cmp_out_oe_o;
  logic [28:0] cmd_word_i;
  logic [21:0] rd_data_o, shadow;
  logic [21:0] expq[$];
  int          failures, compares;
  dsc_setup_regs dut (.*);
  dsc_host_model host (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i), .cmd_word_o(cmd_word_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk_pin(input logic [21:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t pins %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [21:0] got);
    logic [21:0] exp;
    exp = expq.size() > 0 ? expq.pop_front() : ~got;
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t readback %h exp %h", $time, got, exp);
    end
  endtask
  // an answer with no note pending counts as a mismatch
  always @(negedge mclk_i) begin
    if (rd_valid_o === 1'b1) chk_rd(rd_data_o);
    cmp_result_i  <= 4'($urandom);
    guard_alarm_i <= 4'($urandom);
    clamp_alarm_i <= 4'($urandom);
  end
  task automatic wr(input logic [21:0] d);
    shadow = {d[21:2], 2'h0};
    host.wr(d);
  endtask
  task automatic rd();
    expq.push_back(shadow);
    host.rd();
  endtask
  task automatic chan(input logic [3:0] m, input logic c, e);
    @(negedge mclk_i);
    chan_wr_i = m;
    chan_clamp_en_i = c;
    chan_cmp_en_i = e;
    @(negedge mclk_i);
    chan_wr_i = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        shadow[18+i] = c;
        shadow[14+i] = e;
      end
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(38278));
    {rst_i, chan_wr_i, chan_clamp_en_i, chan_cmp_en_i} = 7'h40;
    {cmp_result_i, guard_alarm_i, clamp_alarm_i} = 12'h000;
    shadow = 22'h0;
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    // power-on levels all off
    chk_pin(22'({cmp_out_oe_o, cmp_power_on_o, guard_amp_en_o, shared_alarm_pin_oe_o}), 22'h0);
    rd();
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      wr(22'($urandom));
      chk_pin(22'({sense_short_switch_o, meas_range_unipolar_o, guard_amp_en_o}),
        22'({shadow[9], shadow[7], shadow[8]}));
      chk_pin(22'({ground_sense_per_channel_o, guard_alarm_select_o, clamp_alarm_select_o}),
        22'({shadow[12], shadow[11], shadow[10]}));
      rd();
    end
    $display("test random images done");
    for (int i = 22; i < 28; i++) begin
      host.send((29'h1 << i) | 29'(22'($urandom)));
      host.send((29'h1 << i) | 29'h10000000);
    end
    rd();
    host.send({7'h00, 22'h2AAAAB});
    shadow = 22'h2AAAA8;
    rd();
    $display("test foreign words done");
    wr(22'h002000);
    for (int i = 0; i < 8; i++) begin
      chan(4'(4'h1 << i[1:0]), i[2], ~i[2]);
      chk_pin(22'(cmp_out_oe_o), 22'(shadow[17:14]));
      chk_pin(22'(cmp_out_o), 22'(cmp_result_i & shadow[17:14]));
      rd();
    end
    wr(shadow & ~22'h002000);
    chk_pin(22'(cmp_out_oe_o), 22'h0);
    chan(4'hF, 1'b1, 1'b1);
    wr(22'h000000);
    rd();
    $display("test channel sharing done");
    repeat (3) @(negedge mclk_i);
    print_verdict();
  end
endmodule
bind dsc_setup_regs dsc_checker chk (.*);
`default_nettype wire
